/* verilog/kws_pkg.sv */
package kws_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] KWS_ENABLE_ADDR = 8'h31;
	localparam logic [7:0] KWS_STATUS_ADDR = 8'h32;

	// ----------------------------------------------------------------
	// enable register layout and reset
	// ----------------------------------------------------------------
	localparam int         KWS_KEY_COUNT  = 4;
	localparam int         KWS_EN_LSB     = 4;
	localparam int         KWS_EN_MSB     = 7;
	localparam logic [3:0] KWS_EN_RESET   = 4'h0;

	// ----------------------------------------------------------------
	// status register layout
	// ----------------------------------------------------------------
	localparam int KWS_ST_STOP_BIT = 0;
	localparam int KWS_ST_WARM_BIT = 1;
	localparam int KWS_ST_WAKE_BIT = 2;
	localparam int KWS_ST_EXIT_BIT = 3;
	localparam int KWS_ST_KEY_LSB  = 4;
	localparam int KWS_ST_KEY_MSB  = 7;

	// ----------------------------------------------------------------
	// pin idle levels held in the synchronisers at reset
	// ----------------------------------------------------------------
	localparam logic [3:0] KWS_KEY_IDLE  = 4'hF;
	localparam logic [0:0] KWS_EXIT_IDLE = 1'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int KWS_CLK_NS      = 50;
	localparam int KWS_WARM_US     = 100;
	localparam int KWS_WARM_CYCLES = (KWS_WARM_US * 1000 + KWS_CLK_NS - 1) / KWS_CLK_NS;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		KWS_RUN  = 2'h0,
		KWS_STOP = 2'h1,
		KWS_WARM = 2'h3
	} kws_state_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic       wr;
		logic       rd;
	} kws_bus_type;

endpackage : kws_pkg

/* verilog/kws_sync.sv */
`timescale 1ns/10ps
module kws_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// pins in, synchronised out
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic stage1_q;
			logic stage1_d;
			logic stage2_q;
			logic stage2_d;

			always_comb begin
				stage1_d = asyncIn[gi];
				stage2_d = stage1_q;
			end

			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					stage1_q <= RESET_VAL[gi];
					stage2_q <= RESET_VAL[gi];
				end else begin
					stage1_q <= stage1_d;
					stage2_q <= stage2_d;
				end
			end

			assign syncOut[gi] = stage2_q;
		end
	endgenerate

endmodule : kws_sync

/* verilog/kws_warmup.sv */
`timescale 1ns/10ps
module kws_warmup #(
	parameter int CYCLES = kws_pkg::KWS_WARM_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// control
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	localparam int CNT_W = $clog2(CYCLES + 1);

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic             busy_q;
	logic             busy_d;
	logic             done_q;
	logic             done_d;

	// busy for exactly CYCLES cycles, then one done pulse
	always_comb begin
		count_d = count_q;
		busy_d  = busy_q;
		done_d  = 1'b0;
		if (start) begin
			count_d = CNT_W'(CYCLES - 1);
			busy_d  = 1'b1;
		end else if (busy_q) begin
			if (count_q == '0) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end else begin
				count_d = count_q - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= '0;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			count_q <= count_d;
			busy_q  <= busy_d;
			done_q  <= done_d;
		end
	end

	assign busy = busy_q;
	assign done = done_q;

endmodule : kws_warmup

/* verilog/kws_stop_release.sv */
`timescale 1ns/10ps
// Overview of operation
// - write-only enable register at 0x31, one enable bit per key input
// - bit7 key five, bit6 four, bit5 three, bit4 two; bits 3..0 unused
// - low level on an enabled key input ends stop mode
// - standby-exit pin also ends stop mode
// - stop request with wake already present goes straight to warm-up
// - exit pin has no enable; it always releases stop
module kws_stop_release #(
	parameter int WARM_CYCLES = kws_pkg::KWS_WARM_CYCLES
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// register port
	input  wire kws_pkg::kws_bus_type bus,
	output logic [7:0]                regRdData,
	// system control side
	input  wire logic                 stopReq,
	input  wire logic                 releaseModeSelect,
	// wake pins
	input  wire logic [3:0]           keyWakeIn,
	input  wire logic                 exitPin,
	// power state
	output logic                      stopActive,
	output logic                      warmUpActive,
	output logic                      wakeRequest,
	output logic                      releaseDone
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] keySync;
	logic [0:0] exitSync;

	kws_sync #(
		.WIDTH     (4),
		.RESET_VAL (kws_pkg::KWS_KEY_IDLE)
	) u_key_sync (
		.clk     (clk),
		.rst_b   (rst_b),
		.asyncIn (keyWakeIn),
		.syncOut (keySync)
	);

	kws_sync #(
		.WIDTH     (1),
		.RESET_VAL (kws_pkg::KWS_EXIT_IDLE)
	) u_exit_sync (
		.clk     (clk),
		.rst_b   (rst_b),
		.asyncIn (exitPin),
		.syncOut (exitSync)
	);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [3:0] enable_q;
	logic [3:0] enable_d;
	logic [7:0] rdData_q;
	logic [7:0] rdData_d;
	logic [7:0] statusWord;

	kws_pkg::kws_state_type state_q;
	kws_pkg::kws_state_type state_d;
	logic                   exitPrev_q;
	logic                   wakeReq_q;
	logic                   stop_q;
	logic                   stop_d;

	logic       keyWake;
	logic       exitLevel;
	logic       exitEdge;
	logic       wakeNow;
	logic       warmStart;
	logic       warmBusy;
	logic       warmDone;

	// status word; key levels let software check them before stop
	always_comb begin
		statusWord = 8'h00;
		statusWord[kws_pkg::KWS_ST_STOP_BIT] = stop_q;
		statusWord[kws_pkg::KWS_ST_WARM_BIT] = warmBusy;
		statusWord[kws_pkg::KWS_ST_WAKE_BIT] = wakeReq_q;
		statusWord[kws_pkg::KWS_ST_EXIT_BIT] = exitSync[0];
		statusWord[kws_pkg::KWS_ST_KEY_MSB:kws_pkg::KWS_ST_KEY_LSB] = keySync;
	end

	always_comb begin
		enable_d = enable_q;
		rdData_d = 8'h00;
		if (bus.wr && bus.addr == kws_pkg::KWS_ENABLE_ADDR) begin
			enable_d = bus.wrData[kws_pkg::KWS_EN_MSB:kws_pkg::KWS_EN_LSB];
		end
		if (bus.rd && bus.addr == kws_pkg::KWS_STATUS_ADDR) begin
			rdData_d = statusWord;
		end
		// enable register is write-only and reads as zero
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			enable_q <= kws_pkg::KWS_EN_RESET;
			rdData_q <= 8'h00;
		end else begin
			enable_q <= enable_d;
			rdData_q <= rdData_d;
		end
	end

	// ----------------------------------------------------------------
	// wake detection
	// ----------------------------------------------------------------
	always_comb begin
		keyWake   = |(~keySync & enable_q);
		exitLevel = exitSync[0];
		exitEdge  = exitSync[0] & ~exitPrev_q;
		wakeNow   = keyWake | exitLevel;
	end

	// ----------------------------------------------------------------
	// stop / warm-up sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d   = state_q;
		warmStart = 1'b0;
		case (state_q)
			kws_pkg::KWS_RUN: begin
				if (stopReq) begin
					if (wakeNow) begin
						state_d   = kws_pkg::KWS_WARM;
						warmStart = 1'b1;
					end else begin
						state_d = kws_pkg::KWS_STOP;
					end
				end
			end
			kws_pkg::KWS_STOP: begin
				// level mode: exit high releases; edge mode: exit rising edge
				if (keyWake || (releaseModeSelect ? exitLevel : exitEdge)) begin
					state_d   = kws_pkg::KWS_WARM;
					warmStart = 1'b1;
				end
			end
			kws_pkg::KWS_WARM: begin
				if (warmDone) begin
					state_d = kws_pkg::KWS_RUN;
				end
			end
			default: begin
				state_d = kws_pkg::KWS_RUN;
			end
		endcase
		stop_d = (state_d == kws_pkg::KWS_STOP);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= kws_pkg::KWS_RUN;
			exitPrev_q <= 1'b0;
			wakeReq_q  <= 1'b0;
			stop_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			exitPrev_q <= exitSync[0];
			wakeReq_q  <= wakeNow;
			stop_q     <= stop_d;
		end
	end

	kws_warmup #(
		.CYCLES (WARM_CYCLES)
	) u_warmup (
		.clk   (clk),
		.rst_b (rst_b),
		.start (warmStart),
		.busy  (warmBusy),
		.done  (warmDone)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign regRdData    = rdData_q;
	assign stopActive   = stop_q;
	assign warmUpActive = warmBusy;
	assign wakeRequest  = wakeReq_q;
	assign releaseDone  = warmDone;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_stop_idle;
		state_q == kws_pkg::KWS_STOP && !keyWake;
	endsequence

	sequence s_warm_begin;
		state_q == kws_pkg::KWS_WARM && warmBusy;
	endsequence

	a_enable_write_map: assert property (@(posedge clk) disable iff (!rst_b)
		bus.wr && bus.addr == kws_pkg::KWS_ENABLE_ADDR |=>
		enable_q == $past(bus.wrData[kws_pkg::KWS_EN_MSB:kws_pkg::KWS_EN_LSB]))
		else $error("enable bits not taken from data bits 7..4");

	a_enable_read_zero: assert property (@(posedge clk) disable iff (!rst_b)
		bus.rd && bus.addr == kws_pkg::KWS_ENABLE_ADDR |=> regRdData == 8'h00)
		else $error("write-only enable register did not read zero");

	a_key_release: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == kws_pkg::KWS_STOP && keyWake |=> s_warm_begin)
		else $error("enabled low key did not release stop");

	a_exit_release: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == kws_pkg::KWS_STOP && releaseModeSelect && exitLevel |=> s_warm_begin)
		else $error("exit pin high did not release stop");

	a_exit_edge_release: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == kws_pkg::KWS_STOP && exitSync[0] && !exitPrev_q |=> s_warm_begin)
		else $error("exit pin rising edge did not release stop");

	a_refuse_stop_entry: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == kws_pkg::KWS_RUN && stopReq && wakeNow |=> !stopActive ##0 s_warm_begin)
		else $error("stop entered although wake was present");

	a_stop_entry_held: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == kws_pkg::KWS_RUN && stopReq && !wakeNow |=> stopActive ##1 (stopActive || warmBusy))
		else $error("clean stop request did not hold stop");

	a_stop_no_wake: assert property (@(posedge clk) disable iff (!rst_b)
		s_stop_idle ##0 (!exitLevel && !exitEdge) |=> state_q == kws_pkg::KWS_STOP)
		else $error("stop left without a wake source");

	a_wake_set: assert property (@(posedge clk) disable iff (!rst_b)
		(|(~keySync & enable_q) || exitSync[0]) |=> wakeRequest)
		else $error("wake source present but no wake request");

	a_wake_clear: assert property (@(posedge clk) disable iff (!rst_b)
		!(|(~keySync & enable_q)) && !exitSync[0] |=> !wakeRequest)
		else $error("wake request without a wake source");

	a_warm_length: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(warmBusy) |-> warmBusy[*2] ##0 !releaseDone)
		else $error("warm-up ended too early");

	// ----------------------------------------------------------------
	// warm-up length tracking for the checks
	// ----------------------------------------------------------------
	// counts sampled busy cycles; holds the full length while done pulses
	localparam int SEEN_W = $clog2(WARM_CYCLES + 2);

	logic [SEEN_W-1:0] warmSeen_q;
	logic [SEEN_W-1:0] warmSeen_d;

	always_comb begin
		warmSeen_d = '0;
		if (warmBusy) begin
			warmSeen_d = warmSeen_q + SEEN_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			warmSeen_q <= '0;
		end else begin
			warmSeen_q <= warmSeen_d;
		end
	end

	sequence s_warm_end;
		state_q == kws_pkg::KWS_WARM && releaseDone;
	endsequence

	a_warm_count: assert property (@(posedge clk) disable iff (!rst_b)
		releaseDone |-> warmSeen_q == SEEN_W'(WARM_CYCLES))
		else $error("warm-up did not last the set number of cycles");

	// stop requests during warm-up are dropped
	a_warm_hold: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == kws_pkg::KWS_WARM && !warmDone |=> state_q == kws_pkg::KWS_WARM)
		else $error("warm-up left before its end");

	a_warm_to_run: assert property (@(posedge clk) disable iff (!rst_b)
		s_warm_end |=> state_q == kws_pkg::KWS_RUN && !warmBusy)
		else $error("warm-up end did not return to run");

	// read data stand one cycle, zero otherwise
	a_read_idle_zero: assert property (@(posedge clk) disable iff (!rst_b)
		!bus.rd |=> regRdData == 8'h00)
		else $error("read data not zero outside a read");

	// status shows the levels seen on the read edge
	a_status_levels: assert property (@(posedge clk) disable iff (!rst_b)
		bus.rd && bus.addr == kws_pkg::KWS_STATUS_ADDR |=>
		regRdData[kws_pkg::KWS_ST_KEY_MSB:kws_pkg::KWS_ST_KEY_LSB] == $past(keySync)
		&& regRdData[kws_pkg::KWS_ST_STOP_BIT] == $past(stopActive))
		else $error("status read does not show key levels and stop");

	a_enable_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!(bus.wr && bus.addr == kws_pkg::KWS_ENABLE_ADDR) |=> $stable(enable_q))
		else $error("enable bits changed without a write");

endmodule : kws_stop_release

/* dv/kws_key_model.sv */
`timescale 1ns/10ps
module kws_key_model (
	// clock
	input  wire logic       clk,
	// bench commands
	input  wire logic [3:0] press,
	input  wire logic       exitHigh,
	input  wire logic       slow,
	// wake pins
	output logic      [3:0] keyWakeIn,
	output logic            exitPin
);
	logic [3:0] pressQ = 4'h0;

	always @(posedge clk) begin
		pressQ <= press;
	end
	// released keys sit at the pull-up level; slow switches lag a cycle
	// pins are inputs of the device and only carry digital levels
	assign keyWakeIn = ~(slow ? pressQ : press);
	// exit switch rests low unless closed
	assign exitPin = exitHigh;
endmodule : kws_key_model

/* dv/test_kws_stop_release.sv */
`timescale 1ns/10ps
module test_kws_stop_release;
	localparam int WARM = 10;
	logic                 clk;
	logic                 rst_b;
	kws_pkg::kws_bus_type bus;
	logic [7:0]           regRdData;
	logic [7:0]           d;
	logic                 stopReq;
	logic                 releaseModeSelect;
	logic [3:0]           keyWakeIn;
	logic                 exitPin;
	logic                 stopActive;
	logic                 warmUpActive;
	logic                 wakeRequest;
	logic                 releaseDone;
	logic [3:0]           press;
	logic                 exitHigh;
	logic                 slow;
	int                   failures;
	int                   compares;

	kws_stop_release #(.WARM_CYCLES(WARM)) DUT (
		.clk(clk), .rst_b(rst_b), .bus(bus), .regRdData(regRdData),
		.stopReq(stopReq), .releaseModeSelect(releaseModeSelect),
		.keyWakeIn(keyWakeIn), .exitPin(exitPin), .stopActive(stopActive),
		.warmUpActive(warmUpActive), .wakeRequest(wakeRequest), .releaseDone(releaseDone)
	);
	kws_key_model keys (
		.clk(clk), .press(press), .exitHigh(exitHigh), .slow(slow),
		.keyWakeIn(keyWakeIn), .exitPin(exitPin)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		bus.addr   <= a;
		bus.wrData <= v;
		bus.wr     <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		v = regRdData;
	endtask : rd

	task stop();
		@(posedge clk);
		stopReq <= 1'b1;
		@(posedge clk);
		stopReq <= 1'b0;
		#1;
	endtask : stop

	task waitWarm();
		int n;
		n = 0;
		while (warmUpActive !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("warmUpActive", warmUpActive, 1);
		if (warmUpActive !== 1'b1) conclude();
	endtask : waitWarm

	// counts warm-up cycles from now to the done pulse; gone already passed
	task waitRelease(input int gone);
		int n;
		int w;
		bit seen;
		n = 0;
		w = (warmUpActive === 1'b1) ? 1 : 0;
		seen = 0;
		while (!seen && n < 40) begin
			@(posedge clk);
			#1;
			if (warmUpActive === 1'b1) w++;
			if (releaseDone === 1'b1) seen = 1;
			n++;
		end
		check("releaseDone", seen, 1);
		check("warmCycles", w, WARM - gone);
		if (!seen) conclude();
		@(posedge clk);
	endtask : waitRelease

	initial begin
		failures = 0;
		compares = 0;
		rst_b = 1'b0;
		bus = '0;
		stopReq = 1'b0;
		releaseModeSelect = 1'b1;
		press = 4'h0;
		exitHigh = 1'b0;
		slow = 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		check("stopActive", stopActive, 0);
		check("wakeRequest", wakeRequest, 0);
		wr(kws_pkg::KWS_ENABLE_ADDR, 8'hF0);
		rd(kws_pkg::KWS_ENABLE_ADDR, d);
		check("enableRead", d, 8'h00);
		rd(8'h40, d);
		check("unmappedRead", d, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(kws_pkg::KWS_ENABLE_ADDR, 8'h10 << i);
			@(posedge clk);
			press <= ~(4'h1 << i);
			slow  <= i[0];
			repeat (3) @(posedge clk);
			rd(kws_pkg::KWS_STATUS_ADDR, d);
			check("keyLevels", d[7:4], 4'h1 << i);
			stop();
			check("stopEntered", stopActive, 1);
			repeat (4) @(posedge clk);
			#1;
			check("disabledKeys", stopActive, 1);
			rd(kws_pkg::KWS_STATUS_ADDR, d);
			check("statusStop", d[1:0], 2'h1);
			@(posedge clk);
			press <= 4'hF;
			waitWarm();
			check("keyWake", wakeRequest, 1);
			check("stopLeft", stopActive, 0);
			waitRelease(0);
			press <= 4'h0;
		end
		wr(kws_pkg::KWS_ENABLE_ADDR, 8'h80);
		@(posedge clk);
		press <= 4'h8;
		slow  <= 1'b0;
		repeat (3) @(posedge clk);
		stop();
		check("keyLowWarm", warmUpActive, 1);
		check("keyLowNoStop", stopActive, 0);
		rd(kws_pkg::KWS_STATUS_ADDR, d);
		check("statusWarm", d[1:0], 2'h2);
		waitRelease(2);
		press <= 4'h0;
		wr(kws_pkg::KWS_ENABLE_ADDR, 8'h00);
		repeat (3) @(posedge clk);
		stop();
		check("stopNoKeys", stopActive, 1);
		@(posedge clk);
		exitHigh <= 1'b1;
		waitWarm();
		waitRelease(0);
		rd(kws_pkg::KWS_STATUS_ADDR, d);
		check("statusExitWake", d[3:2], 2'h3);
		stop();
		check("exitHighWarm", warmUpActive, 1);
		check("exitHighNoStop", stopActive, 0);
		waitRelease(0);
		releaseModeSelect <= 1'b0;
		exitHigh <= 1'b0;
		repeat (3) @(posedge clk);
		stop();
		check("edgeStop", stopActive, 1);
		@(posedge clk);
		exitHigh <= 1'b1;
		waitWarm();
		waitRelease(0);
		conclude();
	end
endmodule : test_kws_stop_release
